// File: logic/iur_pkg.sv
// Purpose: Shared constants and types of the isolated USB repeater link control.
// Assumes: mclk is a free-running internal oscillator at 100 MHz.
// Notes: Times stay in their own unit; cycle counts derive from CLK_MHZ.
package iur_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CNT_W = 19;
  localparam int CLK_MHZ = 100;
  localparam int CONN_FILT_NS = 2500;
  localparam int FS_DISC_NS = 2500;
  localparam int HS_DISC_WIN_NS = 36;
  localparam int RST_DET_NS = 2500;
  localparam int CHIRP_FILT_NS = 2500;
  localparam int LONG_IDLE_NS = 1400;
  localparam int SUSP_MS = 3;
  localparam int L2_DONE_MS = 10;
  localparam int L1_DONE_US = 50;
  // Least times round up to whole cycles
  localparam logic [CNT_W-1:0] CONN_CYC = CNT_W'((CONN_FILT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] FSDIS_CYC = CNT_W'((FS_DISC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] HSDIS_CYC = CNT_W'((HS_DISC_WIN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] RST_CYC = CNT_W'((RST_DET_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] CHIRP_CYC = CNT_W'((CHIRP_FILT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] IDLE_CYC = CNT_W'((LONG_IDLE_NS * CLK_MHZ + 999) / 1000);
  localparam int SUSP_CYC_DEF = SUSP_MS * 1000 * CLK_MHZ;
  localparam int L2_DONE_CYC = L2_DONE_MS * 1000 * CLK_MHZ;
  localparam int L1_DONE_CYC = L1_DONE_US * CLK_MHZ;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_EQ = 12'h008;
  localparam logic [31:0] CTRL_RST = 32'h00000001;
  localparam int CTRL_EN_BIT = 0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    ST_OFF = 4'h0,
    ST_WAIT_CONN = 4'h1,
    ST_ATTACHED = 4'h2,
    ST_RESET = 4'h3,
    ST_IDLE = 4'h4,
    ST_FWD = 4'h5,
    ST_HS_CHK = 4'h6,
    ST_SUSPEND = 4'h7,
    ST_SLEEP = 4'h8
  } iur_state_t;

  typedef enum logic [1:0] {
    LN_SE0 = 2'h0,
    LN_J = 2'h1,
    LN_K = 2'h2,
    LN_SE1 = 2'h3
  } iur_line_t;

  // Eq pin codes: 0 ground, 1 open, 2 tied high
  localparam logic [3:0] EQ_RST = 4'h0;
endpackage

// File: logic/iur_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pin levels.
// Assumes: Inputs are levels, not pulses.
// Notes: Only the second stage may be read.
`timescale 1ns/1ps
module iur_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// File: logic/iur_link_ctrl.sv
// Purpose: Link control of a symmetric isolated USB 2.0 repeater.
// Assumes: Line inputs are digital comparator levels; all pins but the APB port are asynchronous.
// Notes: Upstream/downstream roles are role-relative; side pins map by dsIs2_q.
// How it works
// - Bus activity ignored until both side supplies are good.
// - Side with a line high when the connect filter expires becomes downstream facing; side 2 if both.
// - Connect is a downstream line held high beyond the connect filter time.
// - After connect, matching upstream pull-up is enabled; then wait for reset.
// - Speed low/full taken from pulled-up downstream line at reset start.
// - Chosen speed held until power-down or disconnect.
// - Chirps and HS idle relayed both ways during reset.
// - Chirp handshake sets HS; a reset without handshake clears it.
// - LS/FS disconnect: upstream undriven and downstream SE0 beyond disconnect time.
// - LS/FS disconnect drops upstream pull-up and waits for new connect.
// - HS: after quiet window, sample disconnect detector; drop terminations.
// - Long upstream SE0 is reset, driven downstream; HS idle split reset/suspend.
// - LS/FS: side leaving idle first sets direction; data regenerated across.
// - LS/FS forwarding ends on EOP or long idle; drivers released.
// - HS: first side leaving squelch sets direction; its data relayed.
// - HS forwarding ends when squelch returns to idle; drivers released.
// - Two three-level eq pins per side select one of 9 levels.
// - Eq pins captured only at power-up.
// - Idle over 3 ms is suspend; LS/FS idle held at low power.
// - HS suspend: see downstream FS J, reflect upstream, HS off, within 10 ms.
// - Sleep: keep LS/FS idle or drop HS circuits within 50 us.
// - Resume is K from host or wake K; ends SE0 then J or HS idle.
// - Resume and wake replicated both ways; return to prior speed idle.
`timescale 1ns/1ps
module iur_link_ctrl #(
  parameter int SUSP_CYC = iur_pkg::SUSP_CYC_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic upstreamLinePlus,
  input wire logic upstreamLineMinus,
  input wire logic upSquelch,
  input wire logic upHsDiscDet,
  input wire logic downstreamLinePlus,
  input wire logic downstreamLineMinus,
  input wire logic dnSquelch,
  input wire logic dnHsDiscDet,
  input wire logic supplyOk1,
  input wire logic supplyOk2,
  input wire logic sleepEntry,
  input wire logic [1:0] side1EqSelectHi,
  input wire logic [1:0] side1EqSelectLo,
  input wire logic [1:0] side2EqSelectHi,
  input wire logic [1:0] side2EqSelectLo,
  output logic upDrvPlus,
  output logic upDrvMinus,
  output logic upDrvEn,
  output logic upHsDrvEn,
  output logic upHsTermEn,
  output logic upPullPlus,
  output logic upPullMinus,
  output logic dnDrvPlus,
  output logic dnDrvMinus,
  output logic dnDrvEn,
  output logic dnHsDrvEn,
  output logic dnHsTermEn,
  output logic dnPullPlus,
  output logic dnPullMinus,
  output logic lowPower,
  output logic [3:0] side1EqLevel,
  output logic [3:0] side2EqLevel,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import iur_pkg::*;

  function automatic iur_line_t lineSt(input logic p, input logic m, input logic ls);
    if (p && m) return LN_SE1;
    if (!p && !m) return LN_SE0;
    return ((ls ? m : p) ? LN_J : LN_K);
  endfunction

  function automatic logic [CNT_W-1:0] cntNext(input logic [CNT_W-1:0] c, input logic cond);
    if (!cond) return '0;
    return (&c) ? c : c + 1'b1;
  endfunction

  function automatic logic [3:0] eqLevel(input logic [1:0] hi, input logic [1:0] lo);
    return 4'(hi) * 4'h3 + 4'(lo);
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [18:0] syncQ;
  iur_sync #(.W(19)) uSync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({side2EqSelectHi, side2EqSelectLo, side1EqSelectHi, side1EqSelectLo, sleepEntry, supplyOk2, supplyOk1,
        dnSquelch, dnHsDiscDet, downstreamLineMinus, downstreamLinePlus,
        upSquelch, upHsDiscDet, upstreamLineMinus, upstreamLinePlus}),
    .q(syncQ)
  );

  iur_state_t state_q, state_d;
  logic dsIs2_q, pullP_q, pullM_q, ls_q, hs_q, speedSet_q;
  logic devChirp_q, hostChirp_q, dir_q, resume_q, seenSe0_q, eqTaken_q;
  logic [CNT_W-1:0] cntA_q, cntB_q, cntS_q;
  logic [31:0] ctrl_q;
  logic condA, condB, condS;
  logic [3:0] s1, s2, us, ds, src;
  iur_line_t usLn, dsLn, srcLn;
  logic pwrOk, supOk, sleepIn, connDone, fsDisc, hsDisc, rstDet, suspDet;
  logic startUs, startDs, hsOk, hostAct, fwdEnd;

  // Per side: [0] plus, [1] minus, [2] HS disconnect detector, [3] squelch active
  assign s1 = syncQ[3:0];
  assign s2 = syncQ[7:4];
  assign us = dsIs2_q ? s1 : s2;
  assign ds = dsIs2_q ? s2 : s1;
  assign src = dir_q ? us : ds;
  assign usLn = lineSt(us[0], us[1], ls_q);
  assign dsLn = lineSt(ds[0], ds[1], ls_q);
  assign srcLn = lineSt(src[0], src[1], ls_q);
  assign pwrOk = syncQ[8] & syncQ[9];
  assign supOk = pwrOk & ctrl_q[CTRL_EN_BIT];
  assign sleepIn = syncQ[10];

  // ************************************************************
  // Condition timers
  // ************************************************************
  always_comb begin
    condA = 1'b0;
    condB = 1'b0;
    condS = 1'b0;
    unique case (state_q)
      ST_WAIT_CONN: condB = |{s1[1:0], s2[1:0]};
      ST_ATTACHED: begin
        condA = usLn == LN_SE0;
        condB = dsLn == LN_SE0 && usLn != LN_SE0;
      end
      ST_RESET: begin
        condA = usLn == LN_J;
        condB = usLn == LN_SE0 && dsLn == LN_SE0;
      end
      ST_IDLE: begin
        if (hs_q) begin
          condB = !us[3] && !ds[3];
          condS = !us[3] && !ds[3];
        end else begin
          condA = usLn == LN_SE0;
          condB = dsLn == LN_SE0 && usLn != LN_SE0;
          condS = usLn == LN_J && dsLn == LN_J;
        end
      end
      ST_HS_CHK: begin
        condA = usLn == LN_SE0 && dsLn == LN_SE0;
        condS = dsLn == LN_J;
      end
      ST_FWD: condS = srcLn == LN_J;
      default: ;
    endcase
  end

  // Plain counters on mclk: no other time base exists
  always_ff @(posedge mclk) begin
    if (!rst_n || state_d != state_q) begin
      cntA_q <= '0;
      cntB_q <= '0;
      cntS_q <= '0;
    end else begin
      cntA_q <= cntNext(cntA_q, condA);
      cntB_q <= cntNext(cntB_q, condB);
      cntS_q <= cntNext(cntS_q, condS);
    end
  end

  assign connDone = state_q == ST_WAIT_CONN && cntB_q >= CONN_CYC;
  assign fsDisc = (state_q == ST_ATTACHED || (state_q == ST_IDLE && !hs_q)) && cntB_q >= FSDIS_CYC;
  assign hsDisc = state_q == ST_IDLE && hs_q && cntB_q >= HSDIS_CYC && ds[2];
  assign rstDet = (state_q == ST_ATTACHED || (state_q == ST_IDLE && !hs_q)) && cntA_q >= RST_CYC;
  assign suspDet = state_q == ST_IDLE && cntS_q >= CNT_W'(SUSP_CYC);
  assign startUs = hs_q ? us[3] : usLn == LN_K;
  assign startDs = hs_q ? ds[3] : dsLn == LN_K;
  assign hsOk = devChirp_q && hostChirp_q;
  assign hostAct = devChirp_q && usLn != LN_SE0;
  assign fwdEnd = (hs_q && !resume_q) ? !src[3]
                : (seenSe0_q && srcLn == LN_J) || (hs_q && resume_q && seenSe0_q)
                  || (!resume_q && cntS_q >= IDLE_CYC);

  // ************************************************************
  // Link state machine
  // ************************************************************
  always_comb begin
    state_d = state_q;
    if (!supOk) begin
      state_d = ST_OFF;
    end else begin
      unique case (state_q)
        ST_OFF: state_d = ST_WAIT_CONN;
        ST_WAIT_CONN: if (connDone) state_d = ST_ATTACHED;
        ST_ATTACHED: begin
          if (fsDisc) state_d = ST_WAIT_CONN;
          else if (rstDet) state_d = ST_RESET;
        end
        ST_RESET: begin
          if (hsOk && cntB_q >= CHIRP_CYC) state_d = ST_IDLE;
          else if (cntA_q >= CHIRP_CYC) state_d = ST_IDLE;
        end
        ST_IDLE: begin
          if (fsDisc || hsDisc) state_d = ST_WAIT_CONN;
          else if (sleepIn) state_d = ST_SLEEP;
          else if (suspDet) state_d = hs_q ? ST_HS_CHK : ST_SUSPEND;
          else if (rstDet) state_d = ST_RESET;
          else if (startUs || startDs) state_d = ST_FWD;
        end
        ST_HS_CHK: begin
          if (cntS_q >= CHIRP_CYC) state_d = ST_SUSPEND;
          else if (cntA_q >= CHIRP_CYC) state_d = ST_RESET;
        end
        ST_FWD: if (fwdEnd) state_d = ST_IDLE;
        ST_SUSPEND, ST_SLEEP: if (usLn == LN_K || dsLn == LN_K) state_d = ST_FWD;
        default: state_d = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) state_q <= ST_OFF;
    else state_q <= state_d;
  end

  // ************************************************************
  // Role, pull-ups and speed
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n || state_d == ST_OFF || state_d == ST_WAIT_CONN) begin
      if (!rst_n || state_d == ST_OFF) dsIs2_q <= 1'b0;
      pullP_q <= 1'b0;
      pullM_q <= 1'b0;
      ls_q <= 1'b0;
      hs_q <= 1'b0;
      speedSet_q <= 1'b0;
      if (rst_n && state_q == ST_WAIT_CONN && state_d == ST_WAIT_CONN && !(|s1[1:0]) && !(|s2[1:0])) begin
        dsIs2_q <= dsIs2_q;
      end
    end else begin
      if (connDone) begin
        dsIs2_q <= |s2[1:0];
        pullP_q <= (|s2[1:0]) ? s2[0] : s1[0];
        pullM_q <= (|s2[1:0]) ? s2[1] : s1[1];
      end
      if (state_d == ST_RESET && state_q != ST_RESET && !speedSet_q) begin
        ls_q <= ds[1] && !ds[0];
        speedSet_q <= 1'b1;
      end
      if (state_q == ST_RESET && state_d == ST_IDLE) hs_q <= hsOk;
    end
  end

  // ************************************************************
  // Chirp tracking and transfer direction
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n || state_q != ST_RESET) begin
      devChirp_q <= 1'b0;
      hostChirp_q <= 1'b0;
    end else begin
      // A pulled-up idle J is not a chirp; only a device K counts
      if (dsLn == LN_K) devChirp_q <= 1'b1;
      if (hostAct) hostChirp_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dir_q <= 1'b0;
      resume_q <= 1'b0;
      seenSe0_q <= 1'b0;
    end else if (state_q != ST_FWD && state_d == ST_FWD) begin
      dir_q <= (state_q == ST_IDLE) ? startUs : usLn == LN_K;
      resume_q <= state_q != ST_IDLE;
      seenSe0_q <= 1'b0;
    end else if (state_q == ST_FWD) begin
      if (srcLn == LN_SE0) seenSe0_q <= 1'b1;
      // Host takes over once the wake K ends
      if (resume_q && !dir_q && dsLn != LN_K) dir_q <= 1'b1;
    end
  end

  // ************************************************************
  // Line drive, role-relative, then mapped onto side pins
  // ************************************************************
  logic [2:0] usDrv, dsDrv;
  logic usHs, dsHs, hsTerm, lowPwr;

  always_comb begin
    usDrv = 3'h0;
    dsDrv = 3'h0;
    usHs = 1'b0;
    dsHs = 1'b0;
    hsTerm = hs_q && (state_q == ST_IDLE || state_q == ST_FWD);
    lowPwr = state_q == ST_SUSPEND || state_q == ST_SLEEP;
    unique case (state_q)
      ST_RESET: begin
        if (dsLn == LN_K && !hostAct) usDrv = {1'b1, ds[1:0]};
        else dsDrv = {1'b1, hostAct ? us[1:0] : 2'h0};
      end
      ST_FWD: begin
        if (hs_q && !resume_q) begin
          usHs = !dir_q;
          dsHs = dir_q;
        end else if (dir_q) begin
          dsDrv = {1'b1, us[1:0]};
        end else begin
          usDrv = {1'b1, ds[1:0]};
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {upDrvEn, upDrvMinus, upDrvPlus, dnDrvEn, dnDrvMinus, dnDrvPlus} <= 6'h00;
      {upHsDrvEn, dnHsDrvEn, upHsTermEn, dnHsTermEn, lowPower} <= 5'h00;
      {upPullPlus, upPullMinus, dnPullPlus, dnPullMinus} <= 4'h0;
    end else begin
      {upDrvEn, upDrvMinus, upDrvPlus} <= dsIs2_q ? usDrv : dsDrv;
      {dnDrvEn, dnDrvMinus, dnDrvPlus} <= dsIs2_q ? dsDrv : usDrv;
      upHsDrvEn <= dsIs2_q ? usHs : dsHs;
      dnHsDrvEn <= dsIs2_q ? dsHs : usHs;
      upHsTermEn <= hsTerm;
      dnHsTermEn <= hsTerm;
      lowPower <= lowPwr;
      // Pull-up sits only on the upstream-facing side
      upPullPlus <= dsIs2_q && pullP_q;
      upPullMinus <= dsIs2_q && pullM_q;
      dnPullPlus <= !dsIs2_q && pullP_q;
      dnPullMinus <= !dsIs2_q && pullM_q;
    end
  end

  // ************************************************************
  // Equalisation straps
  // ************************************************************
  // Sampled once at first power-good; later pin changes are ignored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      eqTaken_q <= 1'b0;
      side1EqLevel <= EQ_RST;
      side2EqLevel <= EQ_RST;
    end else if (!eqTaken_q && pwrOk) begin
      eqTaken_q <= 1'b1;
      side1EqLevel <= eqLevel(syncQ[14:13], syncQ[12:11]);
      side2EqLevel <= eqLevel(syncQ[18:17], syncQ[16:15]);
    end
  end

  // ************************************************************
  // APB slave, one wait state
  // ************************************************************
  logic apbSetup;
  assign apbSetup = psel && penable && !pready;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl_q <= CTRL_RST;
    end else begin
      pready <= apbSetup;
      pslverr <= apbSetup && paddr != REG_CTRL && paddr != REG_STAT && paddr != REG_EQ;
      if (apbSetup) begin
        unique case (paddr)
          REG_CTRL: prdata <= {31'h00000000, ctrl_q[0]};
          REG_STAT: prdata <= {21'h000000, pwrOk, lowPwr, hs_q, ls_q, speedSet_q, dsIs2_q, 1'b0, state_q};
          REG_EQ: prdata <= {24'h000000, side2EqLevel, side1EqLevel};
          default: prdata <= 32'h00000000;
        endcase
      end
      if (psel && penable && pready && pwrite && paddr == REG_CTRL) ctrl_q <= {31'h00000000, pwdata[0]};
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_idleSleep;
    state_q == ST_IDLE && supOk && sleepIn && !fsDisc && !hsDisc;
  endsequence
  sequence s_lowPwrOn;
    state_q == ST_SLEEP ##1 lowPower;
  endsequence

  property p_noPower;
    !supOk |=> state_q == ST_OFF ##1 !upDrvEn && !dnDrvEn;
  endproperty
  a_noPower: assert property (p_noPower) else $error("activity while supply down");

  property p_connFilt;
    state_q == ST_WAIT_CONN && state_d == ST_ATTACHED |-> cntB_q >= CONN_CYC;
  endproperty
  a_connFilt: assert property (p_connFilt) else $error("connect before filter time");

  property p_pullMatch;
    $rose(state_q == ST_ATTACHED) |-> (pullP_q == ds[0] && pullM_q == ds[1]) ##1 (upPullPlus | upPullMinus | dnPullPlus | dnPullMinus);
  endproperty
  a_pullMatch: assert property (p_pullMatch) else $error("upstream pull-up missing");

  property p_discDrop;
    (state_q == ST_ATTACHED || (state_q == ST_IDLE && !hs_q)) && state_d == ST_WAIT_CONN
      |-> cntB_q >= FSDIS_CYC ##1 !pullP_q && !pullM_q;
  endproperty
  a_discDrop: assert property (p_discDrop) else $error("disconnect handling wrong");

  property p_speedHold;
    speedSet_q && state_d != ST_WAIT_CONN && state_d != ST_OFF |=> $stable(ls_q);
  endproperty
  a_speedHold: assert property (p_speedHold) else $error("speed changed while locked");

  property p_idleQuiet;
    state_q == ST_IDLE |=> !upDrvEn && !dnDrvEn && !upHsDrvEn && !dnHsDrvEn;
  endproperty
  a_idleQuiet: assert property (p_idleQuiet) else $error("driver on during idle");

  property p_suspTime;
    state_q == ST_IDLE && state_d == ST_SUSPEND |-> cntS_q >= CNT_W'(SUSP_CYC) && !hs_q;
  endproperty
  a_suspTime: assert property (p_suspTime) else $error("suspend entered early");

  property p_sleepIn;
    s_idleSleep |=> s_lowPwrOn;
  endproperty
  a_sleepIn: assert property (p_sleepIn) else $error("sleep entry late");

  property p_eqHold;
    eqTaken_q |=> $stable(side1EqLevel) && $stable(side2EqLevel);
  endproperty
  a_eqHold: assert property (p_eqHold) else $error("eq level changed after power-up");

  property p_hsEnd;
    state_q == ST_FWD && hs_q && !resume_q && !src[3] |=> state_q == ST_IDLE ##1 !upHsDrvEn && !dnHsDrvEn;
  endproperty
  a_hsEnd: assert property (p_hsEnd) else $error("HS drive not released");
endmodule

// File: verif/iur_usb_far.sv
// Purpose: Host and peripheral line model for both pairs of the repeater.
// Assumes: A driver beats a pull-up, a pull-up beats the 15k pulldowns.
// Notes: Undriven, unpulled lines read low through the pulldowns.
`timescale 1ns/1ps
module iur_usb_far
  import iur_pkg::*;
(
  input wire logic hostDrv,
  input wire iur_line_t hostLine,
  input wire logic perPullPlus,
  input wire logic perPullMinus,
  input wire logic upDrvEn,
  input wire logic upDrvPlus,
  input wire logic upDrvMinus,
  input wire logic upPullPlus,
  input wire logic upPullMinus,
  input wire logic dnDrvEn,
  input wire logic dnDrvPlus,
  input wire logic dnDrvMinus,
  output logic upP,
  output logic upM,
  output logic dnP,
  output logic dnM
);
  // Host K, SE0 then release ends resume; a released host leaves the pull-up level
  assign upP = hostDrv ? (hostLine == LN_J) : (upDrvEn ? upDrvPlus : upPullPlus);
  assign upM = hostDrv ? (hostLine == LN_K) : (upDrvEn ? upDrvMinus : upPullMinus);
  assign dnP = dnDrvEn ? dnDrvPlus : perPullPlus;
  assign dnM = dnDrvEn ? dnDrvMinus : perPullMinus;
endmodule

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the repeater link control.
// Assumes: SUSP_CYC shortened to 2000 cycles to keep the run short.
// Notes: Squelch and HS disconnect inputs stay idle; FS path only.
`timescale 1ns/1ps
module tb_top;
  import iur_pkg::*;
  logic mclk = 0, rst_n = 0, hostDrv = 0, perP = 0, perM = 0, ok1 = 1, ok2 = 1, slp = 0;
  iur_line_t hostLine = LN_J;
  logic [1:0] e1h = 2'h2, e1l = 2'h1, e2h = 2'h0, e2l = 2'h2;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic e, uDE, uDP, uDM, uPP, uPM, dDE, dDP, dDM, upP, upM, dnP, dnM, lowPower;
  logic [3:0] lv1;
  int fail_count = 0, compares = 0, n, cyc = 0;
  iur_link_ctrl #(.SUSP_CYC(2000)) i_iur_link_ctrl (.mclk(mclk), .rst_n(rst_n),
    .upstreamLinePlus(upP), .upstreamLineMinus(upM), .upSquelch(1'b0), .upHsDiscDet(1'b0),
    .downstreamLinePlus(dnP), .downstreamLineMinus(dnM), .dnSquelch(1'b0), .dnHsDiscDet(1'b0),
    .supplyOk1(ok1), .supplyOk2(ok2), .sleepEntry(slp), .side1EqSelectHi(e1h),
    .side1EqSelectLo(e1l), .side2EqSelectHi(e2h), .side2EqSelectLo(e2l), .upDrvPlus(uDP),
    .upDrvMinus(uDM), .upDrvEn(uDE), .upHsDrvEn(), .upHsTermEn(), .upPullPlus(uPP),
    .upPullMinus(uPM), .dnDrvPlus(dDP), .dnDrvMinus(dDM), .dnDrvEn(dDE), .dnHsDrvEn(),
    .dnHsTermEn(), .dnPullPlus(), .dnPullMinus(), .lowPower(lowPower), .side1EqLevel(lv1),
    .side2EqLevel(), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  iur_usb_far i_iur_usb_far (.hostDrv(hostDrv), .hostLine(hostLine), .perPullPlus(perP),
    .perPullMinus(perM), .upDrvEn(uDE), .upDrvPlus(uDP), .upDrvMinus(uDM), .upPullPlus(uPP),
    .upPullMinus(uPM), .dnDrvEn(dDE), .dnDrvPlus(dDP), .dnDrvMinus(dDM), .upP(upP),
    .upM(upM), .dnP(dnP), .dnM(dnM));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic wt(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // Holds the request until pready is sampled high, then releases
  task automatic apb(input logic [11:0] a, output logic [31:0] d, output logic er);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= 1'b0;
    paddr <= a;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    d = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    apb(REG_CTRL, r, e);
    chk(r, CTRL_RST);
    apb(REG_EQ, r, e);
    chk(r[7:0], 32'h27);
    apb(12'h00C, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    e1h <= 2'h0;
    wt(10);
    apb(REG_EQ, r, e);
    chk(r[7:0], 32'h27);
    chk(lv1, 32'h7);
  endtask
  task automatic t_uvlo();
    ok2 <= 1'b0;
    perP <= 1'b1;
    wt(400);
    chk(uPP, 32'h0);
    perP <= 1'b0;
    ok2 <= 1'b1;
    wt(10);
  endtask
  task automatic t_connect();
    perP <= 1'b1;
    wt(200);
    chk(uPP, 32'h0);
    for (n = 0; n < 100 && uPP !== 1'b1; n++) @(posedge mclk);
    chk({uPP, uPM}, 32'h2);
    apb(REG_STAT, r, e);
    chk(r[5], 32'h1);
  endtask
  task automatic t_reset();
    hostDrv <= 1'b1;
    hostLine <= LN_SE0;
    for (n = 0; n < 300 && dDE !== 1'b1; n++) @(posedge mclk);
    chk({dDE, dDP, dDM}, 32'h4);
    hostDrv <= 1'b0;
    hostLine <= LN_J;
    for (n = 0; n < 400 && dDE !== 1'b0; n++) @(posedge mclk);
    chk(dDE, 32'h0);
    apb(REG_STAT, r, e);
    chk(r[8:6], 32'h1);
  endtask
  task automatic t_traffic();
    hostDrv <= 1'b1;
    hostLine <= LN_K;
    wt(10);
    chk({dDE, dDP, dDM}, 32'h5);
    hostLine <= LN_SE0;
    wt(17);
    hostDrv <= 1'b0;
    hostLine <= LN_J;
    for (n = 0; n < 200 && dDE !== 1'b0; n++) @(posedge mclk);
    chk(dDE, 32'h0);
  endtask
  task automatic t_suspend();
    wt(1800);
    chk(lowPower, 32'h0);
    for (n = 0; n < 500 && lowPower !== 1'b1; n++) @(posedge mclk);
    chk(lowPower, 32'h1);
    hostDrv <= 1'b1;
    hostLine <= LN_K;
    wt(200);
    chk({dDE, dDP, dDM}, 32'h5);
    hostLine <= LN_SE0;
    wt(134);
    hostDrv <= 1'b0;
    hostLine <= LN_J;
    wt(50);
    chk(lowPower, 32'h0);
  endtask
  task automatic t_sleep();
    slp <= 1'b1;
    for (n = 0; n < 50 && lowPower !== 1'b1; n++) @(posedge mclk);
    chk(lowPower, 32'h1);
    slp <= 1'b0;
    hostDrv <= 1'b1;
    hostLine <= LN_K;
    wt(10);
    chk({dDE, dDP, dDM}, 32'h5);
    hostLine <= LN_SE0;
    wt(134);
    hostDrv <= 1'b0;
    hostLine <= LN_J;
    wt(10);
    chk({lowPower, dDE}, 32'h0);
  endtask
  task automatic t_disc();
    perP <= 1'b0;
    wt(200);
    chk(uPP, 32'h1);
    for (n = 0; n < 150 && uPP !== 1'b0; n++) @(posedge mclk);
    chk(uPP, 32'h0);
  endtask
  // Ceiling well above the roughly 4000 cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    wt(16);
    rst_n <= 1'b1;
    t_regs();
    t_uvlo();
    t_connect();
    t_reset();
    t_traffic();
    t_suspend();
    t_sleep();
    t_disc();
    wrap_up();
  end
endmodule
